/* rtl/mcs_core.sv */
// core datapath: return stack, data memory map, accumulator, alu and status flags
// Contract
// - eight-level pc stack, invisible to software
// - call/interrupt push pc, returns pop it
// - reset points stack index at top
// - full stack withholds interrupt until return
// - call on full stack drops oldest
// - general memory 40h-ffh read and write
// - 20h-2ah decoded as wavetable group
// - other addresses below 40h read zero
// - bit set/clear and alu on memory
// - 00h/02h go through pointers 01h/03h
// - direct indirect-port access reads zero, no write
// - no port-to-port indirect move
// - accumulator at 05h, takes immediates, routes moves
// - full 8-bit alu function set with flags
// - flags at 0ah writable except halt/watchdog; 6-7 zero
// - spill flag: carry or no borrow, rotates through carry
// - nibble flag: low-nibble carry or no borrow
// - null flag on zero result
// - wrap flag: carry-in xor carry-out msb
// - halted flag: kick clears, halt sets
// - watchdog flag: kick/halt clear, timeout sets
// - only pc is saved on call or interrupt
`timescale 1ns/1ps
`include "mcs_defines.svh"
module mcs_core (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic op_valid,
   input wire mcs_pkg::mcs_cmd_s op_cmd,
   output logic op_skip,
   input wire logic call_req,
   input wire logic ret_req,
   input wire logic [15:0] pc_in,
   output logic [15:0] pc_out,
   output logic pc_load,
   input wire logic int_pending,
   output logic int_ack,
   output logic stack_full,
   input wire logic halt_exec,
   input wire logic kick_exec,
   input wire logic wdog_timeout
);
   ////////////////////////////////////////////////////////////////////////////
   // storage
   logic [7:0] pointer_zero;
   logic [7:0] pointer_one;
   logic [7:0] work_accumulator;
   logic spill, nibble, null_res, wrap, halted, wdog;
   logic [7:0] wave [0:`MCS_WAVE_COUNT-1];
   logic [7:0] gpr [0:`MCS_GPR_COUNT-1];
   // stack is private: no map address reaches it
   logic [15:0] stack [0:`MCS_STACK_DEPTH-1];
   logic [2:0] stack_index;
   logic [3:0] stack_count;
   mcs_pkg::mcs_wb_state_e wb_state;

   ////////////////////////////////////////////////////////////////////////////
   // map decode
   // pointers come in as arguments so that a continuous caller sees their changes
   function automatic logic [7:0] resolve(input logic [7:0] a, input logic [7:0] p0, input logic [7:0] p1);
      if (a == `MCS_IND_PORT_ZERO) begin
         resolve = p0;
      end else if (a == `MCS_IND_PORT_ONE) begin
         resolve = p1;
      end else begin
         resolve = a;
      end
   endfunction

   function automatic logic [7:0] map_read(input logic [7:0] a);
      logic [7:0] wi;
      wi = a - `MCS_WAVE_FIRST;
      if (a >= `MCS_GPR_FIRST) begin
         map_read = gpr[a - `MCS_GPR_FIRST];
      end else if (a >= `MCS_WAVE_FIRST && a <= `MCS_WAVE_LAST) begin
         map_read = wave[wi[3:0]];
      end else if (a == `MCS_POINTER_ZERO) begin
         map_read = pointer_zero;
      end else if (a == `MCS_POINTER_ONE) begin
         map_read = pointer_one;
      end else if (a == `MCS_WORK_ACC) begin
         map_read = work_accumulator;
      end else if (a == `MCS_ARITH_FLAGS) begin
         map_read = {2'b00, wdog, halted, wrap, null_res, nibble, spill};
      end else begin
         map_read = `MCS_DATA_RESET;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // wishbone slave: one byte per word, lane 0; ack one cycle after the request
   wire wb_req = wb_cyc_i && wb_stb_i && (wb_state == mcs_pkg::MCS_WB_IDLE);
   // the core owns the write port, so a bus request waits out a busy cycle
   wire wb_take = wb_req && !op_valid;
   wire [7:0] wb_ea = resolve(wb_adr_i[9:2], pointer_zero, pointer_one);
   wire wb_wr = wb_take && wb_we_i && wb_sel_i[0];

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wb_state <= mcs_pkg::MCS_WB_IDLE;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         case (wb_state)
            mcs_pkg::MCS_WB_IDLE: begin
               if (wb_take) begin
                  wb_state <= mcs_pkg::MCS_WB_ACK;
                  wb_ack_o <= 1'b1;
                  wb_dat_o <= {24'h00_0000, map_read(wb_ea)};
               end
            end
            mcs_pkg::MCS_WB_ACK: begin
               wb_state <= mcs_pkg::MCS_WB_IDLE;
               wb_ack_o <= 1'b0;
            end
            default: begin
               wb_state <= mcs_pkg::MCS_WB_IDLE;
               wb_ack_o <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // alu: one operand from memory or immediate, the other is the accumulator
   // a single memory operand per command is why port-to-port moves cannot exist
   wire [7:0] op_ea = resolve(op_cmd.addr, pointer_zero, pointer_one);
   logic [7:0] opnd;
   always_comb opnd = op_cmd.use_imm ? op_cmd.imm : map_read(op_ea);
   wire [7:0] acc = work_accumulator;
   wire sum_c = ({1'b0, acc} + {1'b0, opnd}) > 9'h0ff;
   logic [7:0] result;
   logic do_write, upd_c, upd_ac, upd_z, upd_ov, new_c, new_ac, new_ov, skip;

   always_comb begin
      logic [7:0] b;
      logic cin;
      logic [8:0] sum;
      logic [4:0] lo;
      logic [7:0] s7;
      logic [8:0] dj;
      b = opnd;
      cin = 1'b0;
      sum = 9'h000;
      lo = 5'h00;
      s7 = 8'h00;
      dj = {1'b0, acc};
      result = opnd;
      do_write = 1'b1;
      upd_c = 1'b0;
      upd_ac = 1'b0;
      upd_z = 1'b0;
      upd_ov = 1'b0;
      new_c = spill;
      new_ac = nibble;
      new_ov = wrap;
      skip = 1'b0;
      case (op_cmd.op)
         mcs_pkg::MCS_OP_ADD, mcs_pkg::MCS_OP_ADC, mcs_pkg::MCS_OP_SUB, mcs_pkg::MCS_OP_SBC: begin
            // subtraction is a + ~m + 1; its carry out means no borrow
            b = (op_cmd.op == mcs_pkg::MCS_OP_SUB || op_cmd.op == mcs_pkg::MCS_OP_SBC) ? ~opnd : opnd;
            cin = (op_cmd.op == mcs_pkg::MCS_OP_SUB) ? 1'b1 : (op_cmd.op == mcs_pkg::MCS_OP_ADD) ? 1'b0 : spill;
            sum = {1'b0, acc} + {1'b0, b} + {8'h00, cin};
            lo = {1'b0, acc[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            s7 = {1'b0, acc[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
            result = sum[7:0];
            new_c = sum[8];
            new_ac = lo[4];
            new_ov = s7[7] ^ sum[8];
            upd_c = 1'b1;
            upd_ac = 1'b1;
            upd_ov = 1'b1;
            upd_z = 1'b1;
         end
         mcs_pkg::MCS_OP_DAA: begin
            if (acc[3:0] > 4'h9 || nibble) begin
               dj = dj + 9'h006;
            end
            if (dj[7:4] > 4'h9 || spill || dj[8]) begin
               dj = dj + 9'h060;
            end
            result = dj[7:0];
            new_c = dj[8] | spill;
            upd_c = 1'b1;
         end
         mcs_pkg::MCS_OP_AND: begin
            result = acc & opnd;
            upd_z = 1'b1;
         end
         mcs_pkg::MCS_OP_OR: begin
            result = acc | opnd;
            upd_z = 1'b1;
         end
         mcs_pkg::MCS_OP_XOR: begin
            result = acc ^ opnd;
            upd_z = 1'b1;
         end
         mcs_pkg::MCS_OP_CPL: begin
            result = ~opnd;
            upd_z = 1'b1;
         end
         mcs_pkg::MCS_OP_RL: result = {opnd[6:0], opnd[7]};
         mcs_pkg::MCS_OP_RR: result = {opnd[0], opnd[7:1]};
         mcs_pkg::MCS_OP_RLC: begin
            result = {opnd[6:0], spill};
            new_c = opnd[7];
            upd_c = 1'b1;
         end
         mcs_pkg::MCS_OP_RRC: begin
            result = {spill, opnd[7:1]};
            new_c = opnd[0];
            upd_c = 1'b1;
         end
         mcs_pkg::MCS_OP_INC: begin
            result = opnd + 8'h01;
            upd_z = 1'b1;
         end
         mcs_pkg::MCS_OP_DEC: begin
            result = opnd - 8'h01;
            upd_z = 1'b1;
         end
         mcs_pkg::MCS_OP_MOV: result = opnd;
         mcs_pkg::MCS_OP_SET: result = opnd | (8'h01 << op_cmd.bitn);
         mcs_pkg::MCS_OP_CLR: result = opnd & ~(8'h01 << op_cmd.bitn);
         mcs_pkg::MCS_OP_SZ: begin
            do_write = 1'b0;
            skip = (opnd == 8'h00);
         end
         mcs_pkg::MCS_OP_SNZ: begin
            do_write = 1'b0;
            skip = (opnd != 8'h00);
         end
         default: do_write = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // single write port: the core first, else the bus
   wire core_wr = op_valid && do_write;
   wire [7:0] wr_addr = core_wr ? (op_cmd.to_acc ? `MCS_WORK_ACC : op_ea) : wb_ea;
   wire [7:0] wr_data = core_wr ? result : wb_dat_i[7:0];
   wire wr_en = core_wr || wb_wr;
   wire wr_flags = wr_en && (wr_addr == `MCS_ARITH_FLAGS);
   wire [7:0] wr_widx = wr_addr - `MCS_WAVE_FIRST;
   wire [7:0] wr_gidx = wr_addr - `MCS_GPR_FIRST;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pointer_zero <= `MCS_DATA_RESET;
         pointer_one <= `MCS_DATA_RESET;
         work_accumulator <= `MCS_DATA_RESET;
         op_skip <= 1'b0;
      end else begin
         op_skip <= op_valid && skip;
         if (wr_en && wr_addr == `MCS_POINTER_ZERO) begin
            pointer_zero <= wr_data;
         end
         if (wr_en && wr_addr == `MCS_POINTER_ONE) begin
            pointer_one <= wr_data;
         end
         if (wr_en && wr_addr == `MCS_WORK_ACC) begin
            work_accumulator <= wr_data;
         end
      end
   end

   // arrays carry no reset: their content is undefined after power-up
   always_ff @(posedge core_clk) begin
      if (wr_en && wr_addr >= `MCS_GPR_FIRST) begin
         gpr[wr_gidx] <= wr_data;
      end
      if (wr_en && wr_addr >= `MCS_WAVE_FIRST && wr_addr <= `MCS_WAVE_LAST) begin
         wave[wr_widx[3:0]] <= wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status flags; an explicit write to 0ah beats the alu's own update
   always_ff @(posedge core_clk) begin
      if (rst) begin
         spill <= 1'b0;
         nibble <= 1'b0;
         null_res <= 1'b0;
         wrap <= 1'b0;
         halted <= 1'b0;
         wdog <= 1'b0;
      end else begin
         if (wr_flags) begin
            spill <= wr_data[`MCS_BIT_SPILL];
            nibble <= wr_data[`MCS_BIT_NIBBLE];
            null_res <= wr_data[`MCS_BIT_NULL];
            wrap <= wr_data[`MCS_BIT_WRAP];
         end else if (op_valid) begin
            if (upd_c) spill <= new_c;
            if (upd_ac) nibble <= new_ac;
            if (upd_z) null_res <= (result == 8'h00);
            if (upd_ov) wrap <= new_ov;
         end
         // only these event inputs move halt and watchdog bits; set wins
         if (halt_exec) begin
            halted <= 1'b1;
         end else if (kick_exec) begin
            halted <= 1'b0;
         end
         if (wdog_timeout) begin
            wdog <= 1'b1;
         end else if (kick_exec || halt_exec) begin
            wdog <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // return stack; a return outranks a call, a call outranks an interrupt
   wire full_now = stack_count[3];
   wire do_pop = ret_req;
   wire do_call = call_req && !ret_req;
   wire do_int = int_pending && !call_req && !ret_req && !full_now;
   wire do_push = do_call || do_int;
   wire [2:0] pop_index = stack_index - 3'h1;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         stack_index <= `MCS_STACK_TOP;
         stack_count <= 4'h0;
         pc_out <= 16'h0000;
         pc_load <= 1'b0;
         int_ack <= 1'b0;
         stack_full <= 1'b0;
      end else begin
         pc_load <= do_pop;
         int_ack <= do_int;
         if (do_pop) begin
            pc_out <= stack[pop_index];
            stack_index <= pop_index;
            stack_count <= (stack_count == 4'h0) ? 4'h0 : stack_count - 4'h1;
            stack_full <= 1'b0;
         end else if (do_push) begin
            // on a full stack this overwrites the oldest entry
            stack_index <= stack_index + 3'h1;
            stack_count <= full_now ? stack_count : stack_count + 4'h1;
            stack_full <= (stack_count >= 4'h7);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (do_push && !rst) begin
         stack[stack_index] <= pc_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_int_withheld: assert property (@(posedge core_clk) disable iff (rst)
      stack_full && !ret_req |=> !int_ack) else $error("interrupt acknowledged on full stack");
   a_int_after_ret: assert property (@(posedge core_clk) disable iff (rst)
      stack_full && ret_req && int_pending ##1 int_pending && !call_req && !ret_req |=> int_ack)
      else $error("interrupt not serviced after return");
   a_push_pop_pair: assert property (@(posedge core_clk) disable iff (rst)
      call_req && !ret_req && !full_now ##1 ret_req && !call_req |=> pc_load && pc_out == $past(pc_in, 2))
      else $error("popped pc differs from pushed pc");
   a_index_wrap: assert property (@(posedge core_clk) disable iff (rst)
      do_push && !do_pop |=> stack_index == $past(stack_index) + 3'h1) else $error("stack index did not advance");
   a_full_hold: assert property (@(posedge core_clk) disable iff (rst)
      full_now && call_req && !ret_req |=> stack_full && stack_count == 4'h8) else $error("full stack lost its count");
   a_reset_top: assert property (@(posedge core_clk)
      rst |=> stack_index == `MCS_STACK_TOP && !stack_full) else $error("stack index not at top after reset");
   a_flags_protect: assert property (@(posedge core_clk) disable iff (rst)
      wr_flags && !halt_exec && !kick_exec && !wdog_timeout |=> $stable(halted) && $stable(wdog))
      else $error("flag write changed halt or watchdog bit");
   a_wdog_set_wins: assert property (@(posedge core_clk) disable iff (rst)
      wdog_timeout |=> wdog) else $error("watchdog flag not set on timeout");
   a_halt_sets: assert property (@(posedge core_clk) disable iff (rst)
      halt_exec && !wdog_timeout |=> halted && !wdog) else $error("halt did not set halted flag");
   a_add_carry: assert property (@(posedge core_clk) disable iff (rst)
      op_valid && op_cmd.op == mcs_pkg::MCS_OP_ADD && !wr_flags |=> spill == $past(sum_c))
      else $error("carry flag wrong after add");
   a_ind_direct: assert property (@(posedge core_clk) disable iff (rst)
      wb_take && !wb_we_i && wb_ea == `MCS_IND_PORT_ZERO |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
      else $error("direct indirect-port read not zero");
   a_wb_ack_one: assert property (@(posedge core_clk) disable iff (rst)
      wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
   c_overflow_call: cover property (@(posedge core_clk) disable iff (rst) full_now && call_req);
   c_int_service: cover property (@(posedge core_clk) disable iff (rst) int_ack);
   c_bus_write: cover property (@(posedge core_clk) disable iff (rst) wb_wr);
   c_skip: cover property (@(posedge core_clk) disable iff (rst) op_skip);
endmodule

/* rtl/mcs_defines.svh */
// offsets, field positions, reset values and sizes for the core datapath
`ifndef MCS_DEFINES_SVH
`define MCS_DEFINES_SVH
// data memory map, indices (byte address on the bus is four times these)
`define MCS_IND_PORT_ZERO 8'h00
`define MCS_POINTER_ZERO 8'h01
`define MCS_IND_PORT_ONE 8'h02
`define MCS_POINTER_ONE 8'h03
`define MCS_WORK_ACC 8'h05
`define MCS_ARITH_FLAGS 8'h0a
`define MCS_WAVE_FIRST 8'h20
`define MCS_WAVE_LAST 8'h2a
`define MCS_GPR_FIRST 8'h40
`define MCS_GPR_LAST 8'hff
`define MCS_WAVE_COUNT 11
`define MCS_GPR_COUNT 192
// status bit positions
`define MCS_BIT_SPILL 0
`define MCS_BIT_NIBBLE 1
`define MCS_BIT_NULL 2
`define MCS_BIT_WRAP 3
`define MCS_BIT_HALTED 4
`define MCS_BIT_WDOG 5
// stack geometry, data reset value and pc width
`define MCS_STACK_DEPTH 8
`define MCS_STACK_TOP 3'h0
`define MCS_DATA_RESET 8'h00
`define MCS_PC_WIDTH 16
`endif

/* rtl/mcs_pkg.sv */
// types shared by the core datapath and its users
package mcs_pkg;
   typedef enum logic [4:0] {
      MCS_OP_ADD = 5'h00, MCS_OP_ADC = 5'h01, MCS_OP_SUB = 5'h02, MCS_OP_SBC = 5'h03,
      MCS_OP_DAA = 5'h04, MCS_OP_AND = 5'h05, MCS_OP_OR = 5'h06, MCS_OP_XOR = 5'h07,
      MCS_OP_CPL = 5'h08, MCS_OP_RL = 5'h09, MCS_OP_RR = 5'h0a, MCS_OP_RLC = 5'h0b,
      MCS_OP_RRC = 5'h0c, MCS_OP_INC = 5'h0d, MCS_OP_DEC = 5'h0e, MCS_OP_MOV = 5'h0f,
      MCS_OP_SET = 5'h10, MCS_OP_CLR = 5'h11, MCS_OP_SZ = 5'h12, MCS_OP_SNZ = 5'h13
   } mcs_op_e;
   typedef enum logic [1:0] {
      MCS_WB_IDLE = 2'b01,
      MCS_WB_ACK = 2'b10
   } mcs_wb_state_e;
   // one datapath command: operand is memory at addr or imm, other side is the accumulator
   typedef struct packed {
      mcs_op_e op;
      logic [7:0] addr;
      logic [7:0] imm;
      logic use_imm;
      logic to_acc;
      logic [2:0] bitn;
   } mcs_cmd_s;
endpackage

/* sim/mcs_core_tb.sv */
// self-checking bench for the core datapath
`timescale 1ns/1ps
`include "mcs_defines.svh"
module mcs_core_tb;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic req = 1'b0;
   logic we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [31:0] dat_w = 32'h0;
   logic [31:0] dat_r;
   logic ack;
   logic op_valid = 1'b0;
   mcs_pkg::mcs_cmd_s cmd = '0;
   logic skip, pc_load, int_ack, stack_full;
   logic call_req = 1'b0;
   logic ret_req = 1'b0;
   logic int_pending = 1'b0;
   logic [15:0] pc_in = 16'h0;
   logic [15:0] pc_out;
   logic [2:0] ev = 3'h0;
   int num_errors = 0;
   int n_compared = 0;
   logic [31:0] seed = 32'h6e4f8b1c;
   mcs_pkg::mcs_op_e ops [14] = '{mcs_pkg::MCS_OP_ADD, mcs_pkg::MCS_OP_ADC, mcs_pkg::MCS_OP_SUB,
      mcs_pkg::MCS_OP_SBC, mcs_pkg::MCS_OP_AND, mcs_pkg::MCS_OP_OR, mcs_pkg::MCS_OP_XOR,
      mcs_pkg::MCS_OP_CPL, mcs_pkg::MCS_OP_RL, mcs_pkg::MCS_OP_RR, mcs_pkg::MCS_OP_RLC,
      mcs_pkg::MCS_OP_RRC, mcs_pkg::MCS_OP_INC, mcs_pkg::MCS_OP_DEC};

   always #20 core_clk = ~core_clk;

   // sel tied: only lane 0 carries data
   mcs_core dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .op_valid(op_valid), .op_cmd(cmd), .op_skip(skip), .call_req(call_req), .ret_req(ret_req),
      .pc_in(pc_in), .pc_out(pc_out), .pc_load(pc_load), .int_pending(int_pending), .int_ack(int_ack),
      .stack_full(stack_full), .halt_exec(ev[0]), .kick_exec(ev[1]), .wdog_timeout(ev[2]));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   // expected alu result; f carries the flags across operations
   function automatic logic [7:0] alu(input mcs_pkg::mcs_op_e o, input logic [7:0] a,
      input logic [7:0] b, inout logic [7:0] f);
      logic sub;
      logic cy;
      logic zu;
      logic [7:0] bb;
      logic [8:0] s;
      logic [4:0] h;
      sub = (o == mcs_pkg::MCS_OP_SUB || o == mcs_pkg::MCS_OP_SBC);
      cy = (o == mcs_pkg::MCS_OP_ADC || o == mcs_pkg::MCS_OP_SBC) ? f[0] : sub;
      zu = 1'b1;
      bb = sub ? ~b : b;
      s = {1'b0, a} + {1'b0, bb} + {8'h00, cy};
      h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cy};
      case (o)
         mcs_pkg::MCS_OP_ADD, mcs_pkg::MCS_OP_ADC, mcs_pkg::MCS_OP_SUB, mcs_pkg::MCS_OP_SBC: begin
            f[0] = s[8];
            f[1] = h[4];
            f[3] = s[8] ^ (a[7] ^ bb[7] ^ s[7]);
         end
         mcs_pkg::MCS_OP_AND: s = {1'b0, a & b};
         mcs_pkg::MCS_OP_OR: s = {1'b0, a | b};
         mcs_pkg::MCS_OP_XOR: s = {1'b0, a ^ b};
         mcs_pkg::MCS_OP_CPL: s = {1'b0, ~b};
         mcs_pkg::MCS_OP_INC: s = {1'b0, b + 8'h01};
         mcs_pkg::MCS_OP_DEC: s = {1'b0, b - 8'h01};
         mcs_pkg::MCS_OP_RL: begin
            s = {1'b0, b[6:0], b[7]};
            zu = 1'b0;
         end
         mcs_pkg::MCS_OP_RR: begin
            s = {1'b0, b[0], b[7:1]};
            zu = 1'b0;
         end
         mcs_pkg::MCS_OP_RLC: begin
            s = {b[7], b[6:0], f[0]};
            f[0] = s[8];
            zu = 1'b0;
         end
         mcs_pkg::MCS_OP_RRC: begin
            s = {b[0], f[0], b[7:1]};
            f[0] = s[8];
            zu = 1'b0;
         end
         default: zu = 1'b0;
      endcase
      if (zu) f[2] = (s[7:0] == 8'h00);
      return s[7:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
      int i;
      @(posedge core_clk);
      req <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      dat_w <= {24'h0, d};
      for (i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (ack === 1'b1) break;
      end
      if (i == 20) begin
         num_errors++;
         wrap_up();
      end
      q = dat_r[7:0];
      req <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, idx, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      wb(1'b0, idx, 8'h00, q);
      check({8'h0, q}, {8'h0, exp});
   endtask

   task automatic op(input mcs_pkg::mcs_op_e o, input logic [7:0] a, input logic [7:0] im,
      input logic ui, input logic ta, input logic [2:0] bn, output logic sk);
      @(posedge core_clk);
      op_valid <= 1'b1;
      cmd <= '{o, a, im, ui, ta, bn};
      @(posedge core_clk);
      op_valid <= 1'b0;
      @(negedge core_clk);
      sk = skip;
   endtask

   task automatic st(input logic c, input logic [15:0] pc);
      @(posedge core_clk);
      call_req <= c;
      ret_req <= !c;
      pc_in <= pc;
      @(posedge core_clk);
      call_req <= 1'b0;
      ret_req <= 1'b0;
      @(negedge core_clk);
   endtask

   task automatic pulse(input logic [2:0] v);
      @(posedge core_clk);
      ev <= v;
      @(posedge core_clk);
      ev <= 3'h0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      wrap_up();
   end

   initial begin
      logic [7:0] a, b, res, fl;
      logic sk, ui;
      mcs_pkg::mcs_op_e o;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      rd_chk(`MCS_WORK_ACC, 8'h00);
      rd_chk(`MCS_ARITH_FLAGS, 8'h00);
      check({15'h0, stack_full}, 16'h0);
      rd_chk(8'h10, 8'h00);
      rd_chk(8'h3f, 8'h00);
      for (int k = 0; k < 27; k++) begin
         seed = xs(seed);
         a = (k < 11) ? 8'h20 + k[7:0] : (k == 11) ? 8'h40 : (k == 12) ? 8'hff : seed[7:0] | 8'h40;
         wr(a, seed[15:8]);
         rd_chk(a, seed[15:8]);
      end
      // indirect ports written through datapath ops, read back over the bus and through an op
      wr(`MCS_POINTER_ZERO, 8'h45);
      wr(`MCS_POINTER_ONE, 8'h9c);
      rd_chk(`MCS_POINTER_ONE, 8'h9c);
      op(mcs_pkg::MCS_OP_MOV, `MCS_IND_PORT_ZERO, 8'h5a, 1'b1, 1'b0, 3'h0, sk);
      op(mcs_pkg::MCS_OP_MOV, `MCS_IND_PORT_ONE, 8'ha7, 1'b1, 1'b0, 3'h0, sk);
      rd_chk(8'h45, 8'h5a);
      rd_chk(8'h9c, 8'ha7);
      rd_chk(`MCS_IND_PORT_ZERO, 8'h5a);
      op(mcs_pkg::MCS_OP_MOV, `MCS_IND_PORT_ZERO, 8'h00, 1'b0, 1'b1, 3'h0, sk);
      rd_chk(`MCS_WORK_ACC, 8'h5a);
      wr(`MCS_POINTER_ZERO, 8'h00);
      rd_chk(`MCS_IND_PORT_ZERO, 8'h00);
      op(mcs_pkg::MCS_OP_MOV, `MCS_IND_PORT_ZERO, 8'h33, 1'b1, 1'b0, 3'h0, sk);
      op(mcs_pkg::MCS_OP_MOV, `MCS_IND_PORT_ZERO, 8'h00, 1'b0, 1'b1, 3'h0, sk);
      rd_chk(`MCS_WORK_ACC, 8'h00);
      // alu: corners first, then random
      wr(`MCS_ARITH_FLAGS, 8'h00);
      fl = 8'h00;
      for (int k = 0; k < 40; k++) begin
         seed = xs(seed);
         a = (k == 0) ? 8'hff : (k == 1) ? 8'h7f : (k == 2) ? 8'h33 : seed[7:0];
         b = (k == 0 || k == 1) ? 8'h01 : (k == 2) ? 8'h33 : seed[15:8];
         o = (k < 2) ? mcs_pkg::MCS_OP_ADD : (k == 2) ? mcs_pkg::MCS_OP_SUB : (k < 17) ? ops[k - 3] :
            ops[seed[19:16] % 14];
         ui = seed[20];
         wr(`MCS_WORK_ACC, a);
         if (!ui) wr(8'h80, b);
         op(o, 8'h80, b, ui, 1'b1, 3'h0, sk);
         res = alu(o, a, b, fl);
         rd_chk(`MCS_WORK_ACC, res);
         rd_chk(`MCS_ARITH_FLAGS, fl);
      end
      // decimal adjust corner: low nibble above nine, high nibble pushed past nine by the low adjust
      wr(`MCS_ARITH_FLAGS, 8'h00);
      wr(`MCS_WORK_ACC, 8'h9a);
      op(mcs_pkg::MCS_OP_DAA, 8'h80, 8'h00, 1'b1, 1'b1, 3'h0, sk);
      rd_chk(`MCS_WORK_ACC, 8'h00);
      rd_chk(`MCS_ARITH_FLAGS, 8'h01);
      // flags: writable low bits, protected halt and watchdog bits
      wr(`MCS_ARITH_FLAGS, 8'hff);
      rd_chk(`MCS_ARITH_FLAGS, 8'h0f);
      wr(`MCS_ARITH_FLAGS, 8'h00);
      pulse(3'b001);
      rd_chk(`MCS_ARITH_FLAGS, 8'h10);
      pulse(3'b100);
      wr(`MCS_ARITH_FLAGS, 8'h00);
      rd_chk(`MCS_ARITH_FLAGS, 8'h30);
      pulse(3'b001);
      rd_chk(`MCS_ARITH_FLAGS, 8'h10);
      pulse(3'b010);
      rd_chk(`MCS_ARITH_FLAGS, 8'h00);
      // bit ops and skip decisions
      wr(8'h41, 8'h00);
      op(mcs_pkg::MCS_OP_SET, 8'h41, 8'h00, 1'b0, 1'b0, 3'h5, sk);
      rd_chk(8'h41, 8'h20);
      op(mcs_pkg::MCS_OP_CLR, 8'h41, 8'h00, 1'b0, 1'b0, 3'h5, sk);
      op(mcs_pkg::MCS_OP_SZ, 8'h41, 8'h00, 1'b0, 1'b0, 3'h0, sk);
      check({15'h0, sk}, 16'h1);
      op(mcs_pkg::MCS_OP_SNZ, 8'h41, 8'h00, 1'b0, 1'b0, 3'h0, sk);
      check({15'h0, sk}, 16'h0);
      // stack: overflow drops the oldest, full stack holds the interrupt
      wr(`MCS_ARITH_FLAGS, 8'h0d);
      for (int k = 0; k < 9; k++) begin
         st(1'b1, 16'h1000 + k[15:0]);
         check({15'h0, stack_full}, (k >= 7) ? 16'h1 : 16'h0);
      end
      rd_chk(`MCS_ARITH_FLAGS, 8'h0d);
      @(posedge core_clk);
      int_pending <= 1'b1;
      repeat (6) begin
         @(negedge core_clk);
         check({15'h0, int_ack}, 16'h0);
      end
      st(1'b0, 16'h0abc);
      check({15'h0, pc_load}, 16'h1);
      check(pc_out, 16'h1008);
      for (int i = 0; i < 5 && int_ack !== 1'b1; i++) @(negedge core_clk);
      check({15'h0, int_ack}, 16'h1);
      @(posedge core_clk);
      int_pending <= 1'b0;
      @(negedge core_clk);
      check({15'h0, stack_full}, 16'h1);
      for (int k = 0; k < 8; k++) begin
         st(1'b0, 16'h0000);
         check(pc_out, (k == 0) ? 16'h0abc : 16'h1008 - k[15:0]);
      end
      // call directly followed by a return
      @(posedge core_clk);
      call_req <= 1'b1;
      pc_in <= 16'h2345;
      @(posedge core_clk);
      call_req <= 1'b0;
      ret_req <= 1'b1;
      @(posedge core_clk);
      ret_req <= 1'b0;
      @(negedge core_clk);
      check({15'h0, pc_load}, 16'h1);
      check(pc_out, 16'h2345);
      wrap_up();
   end
endmodule
